// file: tb/core_model.sv
// Purpose: CPU core model issuing halt and stop instructions
// Assumes: Bench pulses a request for one cycle
// Notes: A halted core executes nothing, so requests need run high
`timescale 1ns/10ps

module core_model
  import standby_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Bench requests
  input wire logic halt_req_in,
  input wire logic stop_req_in,
  // Sequencer side
  input wire core_ctl_t core_ctl_in,
  output logic halt_exec_out,
  output logic stop_exec_out
);
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      halt_exec_out <= 1'b0;
      stop_exec_out <= 1'b0;
    end else begin
      halt_exec_out <= halt_req_in && core_ctl_in.run;
      stop_exec_out <= stop_req_in && core_ctl_in.run;
    end
  end
endmodule

// file: tb/standby_reset_sequencer_assertions.sv
// Purpose: Port-level checks of the standby and reset sequencer
// Assumes: ce_in held high; periph_sel_in stable during stop
// Notes: Stop is seen as port_hold with the oscillator off and pins driven
`timescale 1ns/10ps

module seq_checker
  import standby_seq_pkg::*;
#(
  parameter int WAIT15 = 16,
  parameter int WAIT17 = 32
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Watched ports
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic reset_pin_n_in,
  input wire logic watchdog_overflow_in,
  input wire wake_t wake_in,
  input wire core_ctl_t core_out,
  input wire periph_sel_t periph_sel_in,
  input wire periph_en_t periph_en_out
);
  // Synchroniser lag is not exact, so reset waits get a small window
  localparam int W15_HI = WAIT15 + 3;
  localparam int P_LO = WAIT15 + 2;
  localparam int P_HI = WAIT15 + 8;
  localparam int W17_HI = WAIT17 + 4;
  logic in_stop;
  logic wake_pend;
  assign in_stop = core_out.port_hold && !core_out.main_osc_en && !core_out.pin_hiz;
  assign wake_pend = |(wake_in.irq_req & ~wake_in.interrupt_mask_flag);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_osc_wait;
    core_out.main_osc_en && !core_out.run;
  endsequence
  sequence s_resume;
    core_out.run && (core_out.irq_service || core_out.resume_next)
      && (core_out.irq_service == wake_in.global_interrupt_enable);
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_apb_ready;
    psel_in && !penable_in |=> pready_out;
  endproperty
  property p_pready_pulse;
    pready_out |=> !pready_out;
  endproperty
  property p_rst_hiz;
    core_out.core_reset |-> core_out.pin_hiz;
  endproperty
  property p_stop_off;
    in_stop |-> !core_out.run && !periph_en_out.wide_timer && !periph_en_out.watchdog && !periph_en_out.adc;
  endproperty
  property p_stop_ext;
    in_stop |-> periph_en_out.event_counter_a == periph_sel_in.ext_count_input_a
      && periph_en_out.event_counter_b == periph_sel_in.ext_count_input_b
      && periph_en_out.serial == periph_sel_in.serial_ext_clk;
  endproperty
  property p_stop_sub;
    in_stop |-> periph_en_out.narrow_timer_c == (periph_sel_in.sub_osc_running && periph_sel_in.narrow_timer_c_sub)
      && periph_en_out.watch_timer == (periph_sel_in.sub_osc_running && periph_sel_in.watch_timer_sub)
      && periph_en_out.lcd == (periph_sel_in.sub_osc_running && periph_sel_in.lcd_sub)
      && periph_en_out.comparator_ext && periph_en_out.comparator_timer == periph_en_out.narrow_timer_c;
  endproperty
  property p_mask_hold;
    in_stop && !wake_pend && reset_pin_n_in |=> core_out.port_hold && !core_out.main_osc_en;
  endproperty
  property p_stop_wake;
    in_stop && wake_pend |=> s_osc_wait ##[1:W17_HI] s_resume;
  endproperty
  property p_wdt_wait;
    watchdog_overflow_in && core_out.run |-> ##[WAIT15:W15_HI] (core_out.vector_fetch && core_out.run);
  endproperty
  property p_pin_wait;
    $rose(reset_pin_n_in) |-> ##[P_LO:P_HI] core_out.vector_fetch;
  endproperty
  property p_vector;
    core_out.vector_fetch |-> core_out.run && core_out.vector_addr == 16'h0000;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready missing after setup");
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
  a_rst_hiz: assert property (p_rst_hiz) else $error("pins driven during reset");
  a_stop_off: assert property (p_stop_off) else $error("stop left a block running");
  a_stop_ext: assert property (p_stop_ext) else $error("stop external clock gating wrong");
  a_stop_sub: assert property (p_stop_sub) else $error("stop subclock gating wrong");
  a_mask_hold: assert property (p_mask_hold) else $error("stop left without wake source");
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake sequence wrong");
  a_wdt_wait: assert property (p_wdt_wait) else $error("watchdog reset wait wrong");
  a_pin_wait: assert property (p_pin_wait) else $error("pin reset wait wrong");
  a_vector: assert property (p_vector) else $error("vector fetch wrong");
endmodule

bind standby_reset_sequencer seq_checker #(.WAIT15(WAIT15), .WAIT17(WAIT17)) seq_checker_i (
  .clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pready_out(pready_out), .reset_pin_n_in(reset_pin_n_in), .watchdog_overflow_in(watchdog_overflow_in),
  .wake_in(wake_in), .core_out(core_out), .periph_sel_in(periph_sel_in), .periph_en_out(periph_en_out));

// file: tb/tb.sv
// Purpose: Directed bench of the standby and reset sequencer
// Assumes: Short waits 8, 16 and 32 cycles
// Notes: APB answers are taken at the rising edge that sees pready, then released
`timescale 1ns/10ps
`include "standby_seq_defines.svh"

module tb
  import standby_seq_pkg::*;
;
  logic clock_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
  logic reset_pin_n_in, watchdog_overflow_in, halt_exec, stop_exec, halt_req, stop_req;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  wake_t wake_in;
  core_ctl_t core_out;
  periph_sel_t periph_sel_in;
  periph_en_t periph_en_out;
  int miscompares, tests_run;

  standby_reset_sequencer #(.WAIT12(8), .WAIT15(16), .WAIT17(32)) standby_reset_sequencer_i (
    .clock_in(clock_in), .nrst_in(nrst_in), .ce_in(1'b1), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .prdata_out(prdata_out), .reset_pin_n_in(reset_pin_n_in),
    .watchdog_overflow_in(watchdog_overflow_in), .halt_exec_in(halt_exec), .stop_exec_in(stop_exec),
    .wake_in(wake_in), .core_out(core_out), .periph_sel_in(periph_sel_in), .periph_en_out(periph_en_out));
  core_model core_model_i (.clock_in(clock_in), .nrst_in(nrst_in), .halt_req_in(halt_req),
    .stop_req_in(stop_req), .core_ctl_in(core_out), .halt_exec_out(halt_exec), .stop_exec_out(stop_exec));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_of_test();
    $display("Checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    @(posedge clock_in);
    while (pready_out !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        end_of_test();
      end
      @(posedge clock_in);
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task reg_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd & m, exp);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = core_out.vector_fetch;
      1: pick = core_out.irq_service;
      2: pick = core_out.nmi_service;
      default: pick = core_out.resume_next;
    endcase
  endfunction
  task wait_core(input int k);
    int n;
    n = 0;
    @(negedge clock_in);
    while (pick(k) !== 1'b1) begin
      n++;
      if (n > 3000) begin
        miscompares++;
        end_of_test();
      end
      @(negedge clock_in);
    end
  endtask
  task core_op(input logic s);
    @(posedge clock_in);
    halt_req <= !s;
    stop_req <= s;
    @(posedge clock_in);
    halt_req <= 1'b0;
    stop_req <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    {nrst_in, psel_in, penable_in, pwrite_in, halt_req, stop_req, watchdog_overflow_in} = 7'h0;
    {paddr_in, pwdata_in, rd, err, miscompares, tests_run} = '0;
    reset_pin_n_in = 1'b1;
    wake_in = '{irq_req: 8'h00, interrupt_mask_flag: 8'hff, nmi_req: 1'b0, global_interrupt_enable: 1'b0};
    periph_sel_in = 7'h5a;
    repeat (10) @(posedge clock_in);
    nrst_in <= 1'b1;
    wait_core(0);
    reg_chk("ctrl reset", `OFS_CTRL, 32'h7, 32'h4);
    reg_chk("state run", `OFS_STATUS, 32'h7, 32'h2);
    apb(1'b1, `OFS_CTRL, 32'h2);
    reg_chk("ctrl rw", `OFS_CTRL, 32'hffffffff, 32'h2);
    apb(1'b1, `OFS_CTRL, 32'h5);
    reg_chk("ctrl bad code", `OFS_CTRL, 32'hffffffff, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    core_op(1'b0);
    wake_in.irq_req <= 8'h01;
    repeat (5) @(posedge clock_in);
    reg_chk("halt masked", `OFS_STATUS, 32'h7, 32'h3);
    wake_in.interrupt_mask_flag <= 8'hfe;
    wake_in.global_interrupt_enable <= 1'b1;
    wait_core(1);
    wake_in.irq_req <= 8'h00;
    wake_in.global_interrupt_enable <= 1'b0;
    core_op(1'b0);
    wake_in.nmi_req <= 1'b1;
    wait_core(2);
    wake_in.nmi_req <= 1'b0;
    core_op(1'b0);
    reset_pin_n_in <= 1'b0;
    repeat (400) @(posedge clock_in);
    reg_chk("halt reset", `OFS_STATUS, 32'h7, 32'h0);
    check("reset hiz", {31'h0, core_out.pin_hiz}, 32'h1);
    reset_pin_n_in <= 1'b1;
    wait_core(0);
    reg_chk("ctrl after reset", `OFS_CTRL, 32'h7, 32'h4);
    apb(1'b1, `OFS_CTRL, 32'h0);
    core_op(1'b1);
    check("stop periph", {21'h0, periph_en_out}, 32'h287);
    check("stop core", {29'h0, core_out.run, core_out.main_osc_en, core_out.port_hold}, 32'h1);
    wake_in.irq_req <= 8'h02;
    repeat (20) @(posedge clock_in);
    reg_chk("stop masked", `OFS_STATUS, 32'h7, 32'h4);
    wake_in.interrupt_mask_flag <= 8'hfc;
    wait_core(3);
    reg_chk("stop by irq", `OFS_STATUS, 32'h17, 32'h12);
    wake_in.global_interrupt_enable <= 1'b1;
    core_op(1'b1);
    wait_core(1);
    wake_in.irq_req <= 8'h00;
    wake_in.interrupt_mask_flag <= 8'hff;
    core_op(1'b1);
    reset_pin_n_in <= 1'b0;
    repeat (400) @(posedge clock_in);
    check("stop reset", {29'h0, core_out.port_hold, core_out.pin_hiz, core_out.core_reset}, 32'h6);
    reset_pin_n_in <= 1'b1;
    wait_core(0);
    repeat (2) @(posedge clock_in);
    watchdog_overflow_in <= 1'b1;
    @(posedge clock_in);
    watchdog_overflow_in <= 1'b0;
    wait_core(0);
    reg_chk("watchdog cause", `OFS_STATUS, 32'hf, 32'ha);
    end_of_test();
  end
endmodule

// file: verilog/standby_reset_sequencer.sv
// Purpose: Halt, stop and reset sequencing with oscillation waits
// Assumes: clock_in is the main system clock; APB3 register slave
// Notes: Peripheral enables are clock permissions, not mode bits
//
// Contract
// RL1 - Halt ended by reset runs reset sequence
// RL2 - Stop instruction enters stop state
// RL3 - Pending unmasked request wakes standby immediately
// RL4 - Immediate stop wake: halt, wait, resume
// RL5 - Stop halts osc, CPU, timer, watchdog, ADC
// RL6 - Event counters run only on external inputs
// RL7 - Timer C, watch, LCD need subclock
// RL8 - Serial runs only with external clock
// RL9 - Comparator keeps interrupt; timer mode with subclock
// RL10 - Unmasked interrupt ends stop after wait
// RL11 - Masked interrupt never ends stop
// RL12 - Reset ends stop after stabilization wait
// RL13 - Pin and watchdog resets act identically
// RL14 - Reset starts from vector at zero
// RL15 - Pins high-impedance during reset and wait
// RL16 - Pin release waits 2^15 clocks
// RL17 - Watchdog reset self-releases, same wait
// RL18 - External reset low at least 10 us
// RL19 - Reset in stop keeps stop contents
// RL20 - Reset loads 2^17 select; stop uses 2^15 (stop wait here follows the select, so 2^17 after reset)
// RL21 - Unmasked interrupt ends halt
// RL22 - NMI ends halt, always serviced
`timescale 1ns/10ps

module standby_reset_sequencer
  import standby_seq_pkg::*;
#(
  parameter int WAIT12 = `WAIT_EXP12,
  parameter int WAIT15 = `WAIT_EXP15,
  parameter int WAIT17 = `WAIT_EXP17
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Reset sources
  input wire logic reset_pin_n_in,
  input wire logic watchdog_overflow_in,
  // CPU core
  input wire logic halt_exec_in,
  input wire logic stop_exec_in,
  input wire wake_t wake_in,
  output core_ctl_t core_out,
  // Peripheral clock gating
  input wire periph_sel_t periph_sel_in,
  output periph_en_t periph_en_out
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  initial begin
    if (WAIT12 < 1 || WAIT15 < 1 || WAIT17 < 1) begin
      $error("wait lengths must be at least one cycle");
    end
    if (WAIT12 > (1 << `CNT_W) || WAIT15 > (1 << `CNT_W) || WAIT17 > (1 << `CNT_W)) begin
      $error("wait length exceeds counter width");
    end
  end

  localparam logic [`CNT_W-1:0] LOAD12 = `CNT_W'(WAIT12 - 1);
  localparam logic [`CNT_W-1:0] LOAD15 = `CNT_W'(WAIT15 - 1);
  localparam logic [`CNT_W-1:0] LOAD17 = `CNT_W'(WAIT17 - 1);

  seq_regs_t r_q;
  seq_regs_t r_d;

  function automatic logic [`CNT_W-1:0] wait_load(input logic [`SEL_W-1:0] sel);
    logic [`CNT_W-1:0] v;
    v = LOAD17;
    if (sel == `SEL_W12) begin
      v = LOAD12;
    end else if (sel == `SEL_W15) begin
      v = LOAD15;
    end
    return v;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic wake;
    logic pin_rst;
    logic sel_ok;
    logic [31:0] rd;
    r_d = r_q;
    wake = 1'b0;
    pin_rst = 1'b0;
    sel_ok = 1'b0;
    rd = 32'h0000_0000;

    // Pin reset passes three flops; level counts once the last two agree
    r_d.pin_sync = {r_q.pin_sync[1:0], reset_pin_n_in};
    if (r_q.pin_sync[1] == r_q.pin_sync[2]) begin
      r_d.pin_lvl = r_q.pin_sync[2];
    end
    pin_rst = !r_q.pin_lvl;

    // Masked requests are ignored here  // see RL11
    wake = |(wake_in.irq_req & ~wake_in.interrupt_mask_flag);

    r_d.ctl.vector_fetch = 1'b0;
    r_d.ctl.irq_service = 1'b0;
    r_d.ctl.nmi_service = 1'b0;
    r_d.ctl.resume_next = 1'b0;
    r_d.ctl.vector_addr = `RESET_VECTOR;

    if (pin_rst) begin
      // Reset entered from stop keeps stop contents during the pin low  // see RL19
      if (r_q.st == ST_STOP) begin
        r_d.from_stop = 1'b1;
      end
      r_d.st = ST_RST_HOLD;
      r_d.wdt_cause = 1'b0;
    end else if (watchdog_overflow_in) begin
      // Same path as the pin, minus the hold phase  // see RL13 RL17
      r_d.st = ST_RST_WAIT;
      r_d.cnt = LOAD15;
      r_d.wdt_cause = 1'b1;
      r_d.from_stop = 1'b0;
    end else begin
      unique case (r_q.st)
        ST_RST_HOLD: begin
          // Release always waits 2^15, whatever the select holds  // see RL16 RL20 RL12
          r_d.st = ST_RST_WAIT;
          r_d.cnt = LOAD15;
        end
        ST_RST_WAIT: begin
          if (r_q.cnt == '0) begin
            r_d.st = ST_RUN;
            r_d.from_stop = 1'b0;
            r_d.ctl.vector_fetch = 1'b1; // see RL14 RL1
          end else begin
            r_d.cnt = r_q.cnt - 1'b1;
          end
        end
        ST_RUN: begin
          if (stop_exec_in) begin
            r_d.st = ST_STOP; // see RL2
            r_d.irq_wake = 1'b0;
          end else if (halt_exec_in) begin
            r_d.st = ST_HALT;
          end
        end
        ST_HALT: begin
          // A request already pending falls out on the next edge  // see RL3
          if (wake_in.nmi_req) begin
            r_d.st = ST_RUN;
            r_d.ctl.nmi_service = 1'b1; // see RL22
          end else if (wake) begin
            r_d.st = ST_RUN;
            r_d.ctl.irq_service = wake_in.global_interrupt_enable; // see RL21
            r_d.ctl.resume_next = !wake_in.global_interrupt_enable;
          end
        end
        ST_STOP: begin
          // Immediate wake still passes through the halted wait  // see RL3 RL4
          if (wake) begin
            r_d.st = ST_OSC_WAIT;
            r_d.cnt = wait_load(r_q.osc_wait_select);
            r_d.irq_wake = 1'b1;
          end
        end
        ST_OSC_WAIT: begin
          if (r_q.cnt == '0) begin
            r_d.st = ST_RUN;
            r_d.ctl.irq_service = wake_in.global_interrupt_enable; // see RL10
            r_d.ctl.resume_next = !wake_in.global_interrupt_enable;
          end else begin
            r_d.cnt = r_q.cnt - 1'b1;
          end
        end
        default: begin
          r_d.st = ST_RST_WAIT;
          r_d.cnt = LOAD15;
        end
      endcase
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Answer prepared in setup so every bus output is a flop
    unique case (paddr_in)
      `OFS_CTRL: begin
        rd[`SEL_MSB:`SEL_LSB] = r_q.osc_wait_select;
      end
      `OFS_STATUS: begin
        rd[`STAT_STATE_MSB:`STAT_STATE_LSB] = r_q.st;
        rd[`STAT_WDT_BIT] = r_q.wdt_cause;
        rd[`STAT_IRQWAKE_BIT] = r_q.irq_wake;
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
    r_d.pready = 1'b0;
    if (psel_in && !penable_in) begin
      r_d.pready = 1'b1;
      r_d.prdata = pwrite_in ? 32'h0000_0000 : rd;
      r_d.pslverr = (paddr_in != `OFS_CTRL) && (paddr_in != `OFS_STATUS);
    end else if (psel_in && penable_in && r_q.pready) begin
      r_d.prdata = 32'h0000_0000;
      r_d.pslverr = 1'b0;
      if (pwrite_in && paddr_in == `OFS_CTRL) begin
        // Prohibited codes are dropped so the wait length stays defined
        sel_ok = (pwdata_in[`SEL_MSB:`SEL_LSB] == `SEL_W12) ||
                 (pwdata_in[`SEL_MSB:`SEL_LSB] == `SEL_W15) ||
                 (pwdata_in[`SEL_MSB:`SEL_LSB] == `SEL_W17);
        if (sel_ok) begin
          r_d.osc_wait_select = pwdata_in[`SEL_MSB:`SEL_LSB];
        end
      end
    end

    // Core reset reloads the select; a stop-held reset waits for release  // see RL20 RL19
    if (r_d.st == ST_RST_WAIT || (r_d.st == ST_RST_HOLD && !r_d.from_stop)) begin
      r_d.osc_wait_select = `SEL_RESET; // see RL13
    end

    // ----------------------------------------
    // Core and pin controls
    // ----------------------------------------
    r_d.ctl.run = (r_d.st == ST_RUN);
    r_d.ctl.main_osc_en = !(r_d.st == ST_STOP || (r_d.st == ST_RST_HOLD && r_d.from_stop)); // see RL5
    r_d.ctl.port_hold = (r_d.st == ST_HALT) || (r_d.st == ST_STOP) || (r_d.st == ST_OSC_WAIT) ||
                        (r_d.st == ST_RST_HOLD && r_d.from_stop); // see RL5 RL19
    r_d.ctl.pin_hiz = (r_d.st == ST_RST_HOLD) || (r_d.st == ST_RST_WAIT); // see RL15
    r_d.ctl.core_reset = (r_d.st == ST_RST_WAIT) || (r_d.st == ST_RST_HOLD && !r_d.from_stop); // see RL1 RL12

    // ----------------------------------------
    // Peripheral clock permissions
    // ----------------------------------------
    r_d.pen = '0;
    unique case (r_d.st)
      ST_RUN: begin
        r_d.pen = '1;
      end
      ST_HALT, ST_OSC_WAIT: begin
        // A/D has no use without the CPU; everything else keeps its clock
        r_d.pen = '1;
        r_d.pen.adc = 1'b0;
      end
      ST_STOP, ST_RST_HOLD: begin
        if (r_d.st == ST_STOP || r_d.from_stop) begin
          r_d.pen.event_counter_a = periph_sel_in.ext_count_input_a; // see RL6
          r_d.pen.event_counter_b = periph_sel_in.ext_count_input_b; // see RL6
          r_d.pen.narrow_timer_c = periph_sel_in.sub_osc_running && periph_sel_in.narrow_timer_c_sub; // see RL7
          r_d.pen.watch_timer = periph_sel_in.sub_osc_running && periph_sel_in.watch_timer_sub; // see RL7
          r_d.pen.lcd = periph_sel_in.sub_osc_running && periph_sel_in.lcd_sub; // see RL7
          r_d.pen.serial = periph_sel_in.serial_ext_clk; // see RL8
          r_d.pen.comparator_ext = 1'b1; // see RL9
          r_d.pen.comparator_timer = r_d.pen.narrow_timer_c; // see RL9
        end
      end
      default: begin
        r_d.pen = '0;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_q <= '0;
      r_q.st <= ST_RST_HOLD;
      r_q.pin_sync <= 3'h0;
      r_q.osc_wait_select <= `SEL_RESET;
      r_q.ctl.pin_hiz <= 1'b1;
      r_q.ctl.core_reset <= 1'b1;
      r_q.ctl.main_osc_en <= 1'b1;
      r_q.ctl.vector_addr <= `RESET_VECTOR;
    end else if (ce_in) begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready_out = r_q.pready;
  assign pslverr_out = r_q.pslverr;
  assign prdata_out = r_q.prdata;
  assign core_out = r_q.ctl;
  assign periph_en_out = r_q.pen;

endmodule

// file: verilog/standby_seq_defines.svh
// Purpose: Constants for the standby and reset sequencer
// Assumes: APB byte addresses, 32-bit data
// Notes: Definitions only
`ifndef STANDBY_SEQ_DEFINES_SVH
`define STANDBY_SEQ_DEFINES_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SEL_W 3
`define SEL_LSB 0
`define SEL_MSB 2
`define SEL_W12 3'h0
`define SEL_W15 3'h2
`define SEL_W17 3'h4
`define SEL_RESET 3'h4

// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_STATE_LSB 0
`define STAT_STATE_MSB 2
`define STAT_WDT_BIT 3
`define STAT_IRQWAKE_BIT 4

// ----------------------------------------
// Timing, in main clock periods
// ----------------------------------------
`define CNT_W 18
`define WAIT_EXP12 4096
`define WAIT_EXP15 32768
`define WAIT_EXP17 131072

// ----------------------------------------
// Misc
// ----------------------------------------
`define IRQ_NUM 8
`define RESET_VECTOR 16'h0000

`endif

// file: verilog/standby_seq_pkg.sv
// Purpose: Types for the standby and reset sequencer
// Assumes: standby_seq_defines.svh included first
// Notes: Carriers for grouped ports and the module state
`include "standby_seq_defines.svh"

package standby_seq_pkg;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RST_HOLD = 3'b000,
    ST_RST_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b011,
    ST_STOP = 3'b100,
    ST_OSC_WAIT = 3'b101
  } seq_state_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [`IRQ_NUM-1:0] irq_req;
    logic [`IRQ_NUM-1:0] interrupt_mask_flag;
    logic nmi_req;
    logic global_interrupt_enable;
  } wake_t;

  typedef struct packed {
    logic ext_count_input_a;
    logic ext_count_input_b;
    logic sub_osc_running;
    logic narrow_timer_c_sub;
    logic watch_timer_sub;
    logic lcd_sub;
    logic serial_ext_clk;
  } periph_sel_t;

  typedef struct packed {
    logic wide_timer;
    logic event_counter_a;
    logic event_counter_b;
    logic narrow_timer_c;
    logic watch_timer;
    logic watchdog;
    logic serial;
    logic adc;
    logic lcd;
    logic comparator_ext;
    logic comparator_timer;
  } periph_en_t;

  typedef struct packed {
    logic run;
    logic main_osc_en;
    logic port_hold;
    logic pin_hiz;
    logic core_reset;
    logic vector_fetch;
    logic irq_service;
    logic nmi_service;
    logic resume_next;
    logic [15:0] vector_addr;
  } core_ctl_t;

  typedef struct packed {
    seq_state_t st;
    logic [2:0] pin_sync;
    logic pin_lvl;
    logic [`CNT_W-1:0] cnt;
    logic from_stop;
    logic wdt_cause;
    logic irq_wake;
    logic [`SEL_W-1:0] osc_wait_select;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    core_ctl_t ctl;
    periph_en_t pen;
  } seq_regs_t;

endpackage
